// file: core/fsc_defines.vh
// Register offsets, field positions, reset values and codes of the flash sequencer control
`ifndef FSC_DEFINES_VH
`define FSC_DEFINES_VH

`define FSC_ADDR_W 4
`define FSC_OFF_COMMAND 4'h0
`define FSC_OFF_MODE 4'h1
`define FSC_OFF_STAT_HIGH 4'h2
`define FSC_OFF_STAT_LOW 4'h3
`define FSC_OFF_FREQ 4'h4
`define FSC_OFF_START_HIGH 4'h5
`define FSC_OFF_START_LOW 4'h6
`define FSC_OFF_END_HIGH 4'h7
`define FSC_OFF_END_LOW 4'h8

`define FSC_BIT_GO 7
`define FSC_CMD_MSB 2
`define FSC_BIT_AREA 5
`define FSC_BIT_INHIBIT 3
`define FSC_BIT_PROG 1
`define FSC_BIT_DONE 6
`define FSC_BIT_SEQ_FAULT 4
`define FSC_BIT_WR_FAULT 1
`define FSC_BIT_ER_FAULT 0
`define FSC_FREQ_MSB 4
`define FSC_UPPER_MSB 4
`define FSC_END_LOW_LSB 2

`define FSC_CMD_WRITE 3'h1
`define FSC_CMD_ERASE 3'h4
`define FSC_CMD_CLEAR 8'h00

`define FSC_RST_COMMAND 8'h00
`define FSC_RST_MODE 8'h08
`define FSC_RST_FREQ 5'h00
`define FSC_RST_UPPER 5'h00
`define FSC_RST_LOWER 8'h00
`define FSC_RST_ADDR 13'h0000

`define FSC_CODE_BLOCK_BITS 10
`define FSC_DATA_BLOCK_BITS 8

`endif

// file: core/fsc_flash_sequencer_control.v
// Flash sequencer control: register file, command launch and status of the flash array
`timescale 1ns/100ps
`include "fsc_defines.vh"

// Overview of operation
// R01: A command runs when the start bit of the command register is set.
// R02: Command 0x81 launches a write, 0x84 a block erase; low bits select.
// R03: Writing 0x00 to the command register clears all command settings.
// R04: Area select bit zero targets code flash, one targets data flash.
// R05: Inhibit bit blocks erase and write; software clears it first.
// R06: Programming mode is entered while the programming mode bit is one.
// R07: Software uses mode values 0x08, 0x02 and 0x22.
// R08: Done flag in upper status byte sets when a command finishes.
// R09: Done flag clears when the start bit is cleared.
// R10: Sequence fault flag sets on any error detected during a command.
// R11: Write fault flag sets when a write command fails.
// R12: Erase fault flag sets when a block erase fails.
// R13: Software masks the lower status byte with 0x13 for any error.
// R14: Frequency field holds the operating frequency in MHz minus one.
// R15: Frequency setting lies between 1 MHz and 16 MHz.
// R16: Code flash erase covers one 1 Kbyte block between the pointers.
// R17: Start address is five upper bits and eight lower bits, 13 bits.
// R18: Code flash end address uses lower bits 7 to 2, four-byte aligned.
// R19: Software sets code block end low 0xFC and end upper 0x03.
// R20: Data flash erase covers one 256 byte block between the pointers.
// R21: Start is ignored outside programming mode or while inhibited.
module fsc_flash_sequencer_control #(
   parameter CODE_BLOCK_BITS = `FSC_CODE_BLOCK_BITS,
   parameter DATA_BLOCK_BITS = `FSC_DATA_BLOCK_BITS
) (
   input wire clk,
   input wire srst,
   input wire [`FSC_ADDR_W-1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   output reg [7:0] regRdData,
   output reg arrayReq,
   output reg arrayWrite,
   output reg arrayErase,
   output reg arrayDataArea,
   output reg [12:0] arrayStartAddr,
   output reg [12:0] arrayEndAddr,
   output reg [4:0] arrayFreq,
   output reg programModeOn,
   input wire arrayDone,
   input wire arrayFail
);

   localparam ST_IDLE = 1'b0;
   localparam ST_RUN = 1'b1;
   localparam [7:0] RST_MODE = `FSC_RST_MODE;

   reg state;
   reg next_state;
   reg [7:0] sequencerCommand;
   reg areaSelect;
   reg programInhibit;
   reg [4:0] freqMinusOne;
   reg [4:0] startAddrUpper;
   reg [7:0] startAddrLower;
   reg [4:0] endAddrUpper;
   reg [7:0] endAddrLower;
   reg sequenceDone;
   reg sequenceFault;
   reg writeFault;
   reg eraseFault;

   reg wrCommand;
   reg wrMode;
   reg wrFreq;
   reg wrStartHigh;
   reg wrStartLow;
   reg wrEndHigh;
   reg wrEndLow;
   wire goWritten;
   wire [2:0] cmdWritten;
   wire modeReady;
   wire launch;
   wire cmdIsWrite;
   wire cmdIsErase;
   wire [12:0] startAddr;
   wire [12:0] endAddr;
   wire [12:0] codeEndAddr;
   wire rangeBackwards;
   wire dataBlockBad;
   wire codeBlockBad;
   wire rangeBad;
   wire cmdValid;
   wire paramBad;
   wire launchTry;
   wire launchOk;
   wire launchBad;
   wire finish;
   wire goCleared;
   wire arrayFailed;
   wire writeFailed;
   wire eraseFailed;
   wire doneSet;
   wire doneClear;
   reg [7:0] next_rdData;

   // Write strobe decode; status and unmapped offsets ignore writes
   always @* begin
      wrCommand = 1'b0;
      wrMode = 1'b0;
      wrFreq = 1'b0;
      wrStartHigh = 1'b0;
      wrStartLow = 1'b0;
      wrEndHigh = 1'b0;
      wrEndLow = 1'b0;
      if (regWr) begin
         if (regAddr == `FSC_OFF_COMMAND) begin
            wrCommand = 1'b1;
         end else if (regAddr == `FSC_OFF_MODE) begin
            wrMode = 1'b1;
         end else if (regAddr == `FSC_OFF_FREQ) begin
            wrFreq = 1'b1;
         end else if (regAddr == `FSC_OFF_START_HIGH) begin
            wrStartHigh = 1'b1;
         end else if (regAddr == `FSC_OFF_START_LOW) begin
            wrStartLow = 1'b1;
         end else if (regAddr == `FSC_OFF_END_HIGH) begin
            wrEndHigh = 1'b1;
         end else if (regAddr == `FSC_OFF_END_LOW) begin
            wrEndLow = 1'b1;
         end
      end
   end

   assign goWritten = regWrData[`FSC_BIT_GO];
   assign cmdWritten = regWrData[`FSC_CMD_MSB:0];

   // Mode must be programming and not inhibited before a start counts
   assign modeReady = programModeOn && !programInhibit; // R05 R06 R21

   // Start bit written as one while idle launches the selected command
   assign launch = wrCommand && goWritten && (state == ST_IDLE); // R01

   assign cmdIsWrite = (cmdWritten == `FSC_CMD_WRITE); // R02
   assign cmdIsErase = (cmdWritten == `FSC_CMD_ERASE); // R02
   assign cmdValid = cmdIsWrite || cmdIsErase; // R02

   // Thirteen-bit pointers from upper and lower bytes
   assign startAddr = {startAddrUpper, startAddrLower}; // R17
   assign codeEndAddr = {endAddrUpper, endAddrLower[7:`FSC_END_LOW_LSB], 2'b00}; // R18
   assign endAddr = areaSelect ? {endAddrUpper, endAddrLower} : codeEndAddr;

   // Erase range must stay inside one block and not run backwards
   assign rangeBackwards = endAddr < startAddr;
   assign dataBlockBad = (endAddr >> DATA_BLOCK_BITS) != (startAddr >> DATA_BLOCK_BITS); // R20
   assign codeBlockBad = (endAddr >> CODE_BLOCK_BITS) != (startAddr >> CODE_BLOCK_BITS); // R16
   assign rangeBad = cmdIsErase &&
      (rangeBackwards || (areaSelect ? dataBlockBad : codeBlockBad));

   assign paramBad = !cmdValid || rangeBad;
   assign launchTry = launch && modeReady; // R21
   assign launchOk = launchTry && !paramBad;
   assign launchBad = launchTry && paramBad;

   assign finish = (state == ST_RUN) && arrayDone;
   assign goCleared = wrCommand && !goWritten;

   // Outcome of the operation that finishes this cycle
   assign arrayFailed = finish && arrayFail; // R10
   assign writeFailed = arrayFailed && arrayWrite; // R11
   assign eraseFailed = arrayFailed && arrayErase; // R12

   // Done flag conditions; a set in the same cycle as a clear wins
   assign doneSet = finish || launchBad; // R08
   assign doneClear = goCleared || launchOk; // R09

   // Next state of the sequencer
   always @* begin
      next_state = state;
      case (state)
         ST_IDLE: begin
            if (launchOk) begin
               next_state = ST_RUN; // R01
            end
         end
         ST_RUN: begin
            if (arrayDone) begin
               next_state = ST_IDLE;
            end
         end
         default: begin
            next_state = ST_IDLE;
         end
      endcase
   end

   // Sequencer state
   always @(posedge clk) begin
      if (srst) begin
         state <= ST_IDLE;
      end else begin
         state <= next_state;
      end
   end

   // Command register; writing zero clears start and command bits
   always @(posedge clk) begin
      if (srst) begin
         sequencerCommand <= `FSC_RST_COMMAND;
      end else if (wrCommand) begin
         sequencerCommand <= regWrData; // R03
      end
   end

   // Mode control register fields
   always @(posedge clk) begin
      if (srst) begin
         areaSelect <= RST_MODE[`FSC_BIT_AREA];
         programInhibit <= RST_MODE[`FSC_BIT_INHIBIT];
         programModeOn <= RST_MODE[`FSC_BIT_PROG];
      end else if (wrMode) begin
         areaSelect <= regWrData[`FSC_BIT_AREA]; // R04
         programInhibit <= regWrData[`FSC_BIT_INHIBIT]; // R05
         programModeOn <= regWrData[`FSC_BIT_PROG]; // R06
      end
   end

   // Frequency setting, stored as MHz minus one
   always @(posedge clk) begin
      if (srst) begin
         freqMinusOne <= `FSC_RST_FREQ;
      end else if (wrFreq) begin
         freqMinusOne <= regWrData[`FSC_FREQ_MSB:0]; // R14
      end
   end

   // Start pointer registers
   always @(posedge clk) begin
      if (srst) begin
         startAddrUpper <= `FSC_RST_UPPER;
         startAddrLower <= `FSC_RST_LOWER;
      end else begin
         if (wrStartHigh) begin
            startAddrUpper <= regWrData[`FSC_UPPER_MSB:0]; // R17
         end
         if (wrStartLow) begin
            startAddrLower <= regWrData; // R17
         end
      end
   end

   // End pointer registers
   always @(posedge clk) begin
      if (srst) begin
         endAddrUpper <= `FSC_RST_UPPER;
         endAddrLower <= `FSC_RST_LOWER;
      end else begin
         if (wrEndHigh) begin
            endAddrUpper <= regWrData[`FSC_UPPER_MSB:0];
         end
         if (wrEndLow) begin
            endAddrLower <= regWrData;
         end
      end
   end

   // Done flag: set on finish, cleared with the start bit, set wins
   always @(posedge clk) begin
      if (srst) begin
         sequenceDone <= 1'b0;
      end else if (doneSet) begin
         sequenceDone <= 1'b1; // R08
      end else if (doneClear) begin
         sequenceDone <= 1'b0; // R09 R21
      end
   end

   // Sequence fault on a bad command, a bad address range or a failing array operation
   always @(posedge clk) begin
      if (srst) begin
         sequenceFault <= 1'b0;
      end else if (launchBad || arrayFailed) begin
         sequenceFault <= 1'b1; // R10
      end else if (launchOk) begin
         sequenceFault <= 1'b0;
      end
   end

   // Write fault on a failing write
   always @(posedge clk) begin
      if (srst) begin
         writeFault <= 1'b0;
      end else if (writeFailed) begin
         writeFault <= 1'b1; // R11
      end else if (launchOk) begin
         writeFault <= 1'b0;
      end
   end

   // Erase fault on a failing block erase
   always @(posedge clk) begin
      if (srst) begin
         eraseFault <= 1'b0;
      end else if (eraseFailed) begin
         eraseFault <= 1'b1; // R12
      end else if (launchOk) begin
         eraseFault <= 1'b0;
      end
   end

   // Array request held from launch until the array reports done
   always @(posedge clk) begin
      if (srst) begin
         arrayReq <= 1'b0;
      end else if (launchOk) begin
         arrayReq <= 1'b1; // R01
      end else if (finish) begin
         arrayReq <= 1'b0;
      end
   end

   // Operation, area, addresses and frequency captured at launch
   always @(posedge clk) begin
      if (srst) begin
         arrayWrite <= 1'b0;
         arrayErase <= 1'b0;
         arrayDataArea <= 1'b0;
         arrayStartAddr <= `FSC_RST_ADDR;
         arrayEndAddr <= `FSC_RST_ADDR;
         arrayFreq <= `FSC_RST_FREQ;
      end else if (launchOk) begin
         arrayWrite <= cmdIsWrite; // R02
         arrayErase <= cmdIsErase; // R02
         arrayDataArea <= areaSelect; // R04
         arrayStartAddr <= startAddr; // R17
         arrayEndAddr <= endAddr; // R18
         arrayFreq <= freqMinusOne; // R14
      end
   end

   // Read data selection; unmapped offsets read zero
   always @* begin
      next_rdData = 8'h00;
      if (regAddr == `FSC_OFF_COMMAND) begin
         next_rdData = sequencerCommand;
      end else if (regAddr == `FSC_OFF_MODE) begin
         next_rdData[`FSC_BIT_AREA] = areaSelect;
         next_rdData[`FSC_BIT_INHIBIT] = programInhibit;
         next_rdData[`FSC_BIT_PROG] = programModeOn;
      end else if (regAddr == `FSC_OFF_STAT_HIGH) begin
         next_rdData[`FSC_BIT_DONE] = sequenceDone; // R08
      end else if (regAddr == `FSC_OFF_STAT_LOW) begin
         next_rdData[`FSC_BIT_SEQ_FAULT] = sequenceFault; // R10
         next_rdData[`FSC_BIT_WR_FAULT] = writeFault; // R11
         next_rdData[`FSC_BIT_ER_FAULT] = eraseFault; // R12
      end else if (regAddr == `FSC_OFF_FREQ) begin
         next_rdData[`FSC_FREQ_MSB:0] = freqMinusOne;
      end else if (regAddr == `FSC_OFF_START_HIGH) begin
         next_rdData[`FSC_UPPER_MSB:0] = startAddrUpper;
      end else if (regAddr == `FSC_OFF_START_LOW) begin
         next_rdData = startAddrLower;
      end else if (regAddr == `FSC_OFF_END_HIGH) begin
         next_rdData[`FSC_UPPER_MSB:0] = endAddrUpper;
      end else if (regAddr == `FSC_OFF_END_LOW) begin
         next_rdData = endAddrLower;
      end
   end

   // Read data stands only in the cycle after the read strobe
   always @(posedge clk) begin
      if (srst) begin
         regRdData <= 8'h00;
      end else if (regRd) begin
         regRdData <= next_rdData;
      end else begin
         regRdData <= 8'h00;
      end
   end

endmodule // fsc_flash_sequencer_control

// file: tb/fsc_flash_sequencer_control_assertions.sv
// Port assertions of the flash sequencer control
`timescale 1ns/100ps
`include "fsc_defines.vh"
module fsc_flash_sequencer_control_assertions #(
   parameter CODE_BLOCK_BITS = 10,
   parameter DATA_BLOCK_BITS = 8
) (
   input wire clk,
   input wire srst,
   input wire [`FSC_ADDR_W-1:0] regAddr,
   input wire [7:0] regWrData,
   input wire regWr,
   input wire regRd,
   input wire [7:0] regRdData,
   input wire arrayReq,
   input wire arrayWrite,
   input wire arrayErase,
   input wire arrayDataArea,
   input wire [12:0] arrayStartAddr,
   input wire [12:0] arrayEndAddr,
   input wire programModeOn,
   input wire arrayDone
);
   reg goSeen;
   reg goWrite;
   reg modeBit;
   always @(posedge clk) begin
      goSeen <= regWr && regAddr == `FSC_OFF_COMMAND && regWrData[`FSC_BIT_GO];
      goWrite <= regWrData[`FSC_CMD_MSB:0] == `FSC_CMD_WRITE;
      modeBit <= regWrData[`FSC_BIT_PROG];
   end
   default clocking @(posedge clk); endclocking
   default disable iff (srst);
   sequence s_busy;
      arrayReq && !arrayDone;
   endsequence
   sequence s_launch;
      $rose(arrayReq);
   endsequence
   a_read_idle: assert property (!regRd |=> regRdData == 8'h00)
      else $error("read data not zero");
   a_req_hold: assert property (s_busy |=> arrayReq)
      else $error("request dropped early");
   a_req_drop: assert property (arrayReq && arrayDone |=> !arrayReq)
      else $error("request held after done");
   a_launch_cause: assert property (s_launch |-> goSeen && programModeOn)
      else $error("launch without start");
   a_launch_kind: assert property (s_launch |-> arrayWrite == goWrite && arrayErase != goWrite)
      else $error("wrong command kind");
   a_addr_hold: assert property (s_busy |=> $stable(arrayStartAddr) && $stable(arrayEndAddr))
      else $error("address moved while busy");
   a_code_align: assert property (arrayReq && !arrayDataArea |-> arrayEndAddr[1:0] == 2'b00)
      else $error("code end not aligned");
   a_erase_block: assert property ($rose(arrayReq) && arrayErase |->
      arrayEndAddr >= arrayStartAddr
      && (arrayDataArea ? (arrayStartAddr >> DATA_BLOCK_BITS) == (arrayEndAddr >> DATA_BLOCK_BITS)
      : (arrayStartAddr >> CODE_BLOCK_BITS) == (arrayEndAddr >> CODE_BLOCK_BITS)))
      else $error("erase outside one block");
   a_mode_follow: assert property (regWr && regAddr == `FSC_OFF_MODE |=>
      programModeOn == modeBit)
      else $error("mode bit not followed");
endmodule // fsc_flash_sequencer_control_assertions
bind fsc_flash_sequencer_control fsc_flash_sequencer_control_assertions #(
   .CODE_BLOCK_BITS(CODE_BLOCK_BITS), .DATA_BLOCK_BITS(DATA_BLOCK_BITS)
) i_chk (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd, .regRdData, .arrayReq, .arrayWrite,
   .arrayErase, .arrayDataArea, .arrayStartAddr, .arrayEndAddr, .programModeOn, .arrayDone);

// file: tb/test_flash_sequencer_control.sv
// Self-checking testbench of the flash sequencer control
`timescale 1ns/100ps
`include "fsc_defines.vh"
module test_flash_sequencer_control;
   reg clk = 1'b0;
   reg srst = 1'b1;
   reg [`FSC_ADDR_W-1:0] regAddr = 4'h0;
   reg [7:0] regWrData = 8'h00;
   reg regWr = 1'b0;
   reg regRd = 1'b0;
   reg arrayDone = 1'b0;
   reg arrayFail = 1'b0;
   wire [7:0] regRdData;
   wire arrayReq, arrayWrite, arrayErase, arrayDataArea, programModeOn;
   wire [12:0] arrayStartAddr, arrayEndAddr;
   wire [4:0] arrayFreq;
   integer num_errors = 0;
   integer samples_checked = 0;
   integer cycles = 0;
   integer busy = 0;
   integer m [0:15];
   integer b, i;
   fsc_flash_sequencer_control i_dut (.clk, .srst, .regAddr, .regWrData, .regWr, .regRd,
      .regRdData, .arrayReq, .arrayWrite, .arrayErase, .arrayDataArea, .arrayStartAddr,
      .arrayEndAddr, .arrayFreq, .programModeOn, .arrayDone, .arrayFail);
   always #4 clk = ~clk;
   task end_sim;
      if (num_errors == 0 && samples_checked > 0)
         $display("Result: passed");
      else
         $display("Result: failed");
      $finish;
   endtask
   always @(posedge clk) begin
      cycles <= cycles + 1;
      if (cycles == 5000) begin
         num_errors = num_errors + 1;
         end_sim;
      end
   end
   task chk(input [35:0] got, input [35:0] exp);
      samples_checked = samples_checked + 1;
      if (got !== exp) begin
         num_errors = num_errors + 1;
         $display("[FAIL] %0t got %h exp %h", $time, got, exp);
      end
   endtask
   // Model of a command register write
   task go(input [7:0] d);
      reg [12:0] s, e;
      s = {m[5][4:0], m[6][7:0]};
      e = m[1][5] ? {m[7][4:0], m[8][7:0]} : {m[7][4:0], m[8][7:2], 2'b00};
      chk(programModeOn, m[1][1]);
      if (!d[7]) begin
         m[2] = 0;
      end else if (busy == 0 && m[1][1] && !m[1][3]) begin
         if (d[2:0] == 1 || d[2:0] == 4 && e >= s
            && (m[1][5] ? s[12:8] == e[12:8] : s[12:10] == e[12:10])) begin
            busy = d[2:0];
            m[2] = 0;
            m[3] = 0;
         end else begin
            m[2] = 8'h40;
            m[3] = m[3] | 8'h10;
         end
      end
      chk(arrayReq, busy != 0);
      if (busy != 0)
         chk({arrayWrite, arrayErase, arrayDataArea, arrayStartAddr, arrayEndAddr, arrayFreq},
            {busy == 1, busy == 4, m[1][5], s, e, m[4][4:0]});
   endtask
   task wr(input [3:0] a, input [7:0] d);
      @(posedge clk);
      regWr <= 1'b1;
      regAddr <= a;
      regWrData <= d;
      @(posedge clk);
      regWr <= 1'b0;
      #1;
      if (a < 9 && (a < 2 || a > 3))
         m[a] = (a == 4 || a == 5 || a == 7) ? d & 8'h1f : d;
      if (a == 0)
         go(d);
   endtask
   task rd(input [3:0] a);
      @(posedge clk);
      regRd <= 1'b1;
      regAddr <= a;
      @(posedge clk);
      regRd <= 1'b0;
      #1;
      chk(regRdData, a < 9 ? m[a][7:0] : 8'h00);
   endtask
   task fin(input f);
      @(posedge clk);
      arrayDone <= 1'b1;
      arrayFail <= f;
      @(posedge clk);
      arrayDone <= 1'b0;
      #1;
      chk(arrayReq, 0);
      m[2] = 8'h40;
      m[3] = f ? (busy == 1 ? 8'h12 : 8'h11) : 0;
      busy = 0;
   endtask
   initial begin
      b = $urandom(38);
      for (i = 0; i < 16; i = i + 1)
         m[i] = 0;
      m[1] = 8'h08;
      repeat (2) @(posedge clk);
      srst <= 1'b0;
      for (i = 0; i < 16; i = i + 1)
         rd(i);
      wr(0, 8'h81);
      rd(2);
      for (i = 0; i < 8; i = i + 1) begin
         b = $urandom;
         wr(1, i[2] ? 8'h22 : 8'h02);
         wr(4, {4'h0, b[19:16]});
         wr(5, i[2] ? {3'b000, b[4:0]} : {3'b000, b[2:0], 2'b00});
         wr(6, b[15:8]);
         wr(7, i[2] ? {3'b000, b[4:0]} : {3'b000, b[2:0], 2'b11});
         wr(8, 8'hfc);
         wr(0, i[0] ? 8'h84 : 8'h81);
         wr(0, 8'h81);
         fin(i[1] ^ i[0]);
         rd(2);
         rd(3);
         wr(0, 8'h00);
         rd(2);
      end
      wr(7, (m[5] + 1) & 8'h1f);
      wr(0, 8'h84);
      rd(2);
      rd(3);
      wr(0, 8'h00);
      wr(0, 8'h82);
      rd(3);
      wr(1, 8'h0a);
      wr(0, 8'h00);
      wr(0, 8'h81);
      rd(2);
      wr(9, 8'hff);
      wr(1, 8'h08);
      wr(0, 8'h00);
      wr(0, 8'h84);
      for (i = 0; i < 16; i = i + 1)
         rd(i);
      end_sim;
   end
endmodule // test_flash_sequencer_control
